// *** hdl/ext_pin_pkg.sv ***
// shared external pin interface constants and carrier types
package ext_pin_pkg;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 64;
    localparam int CFG_DATA_W = 16;
    localparam int SD_ADDR_LO = 5;
    localparam int SD_ADDR_W = ADDR_W - SD_ADDR_LO;
    localparam logic [1:0] WIDTH_8 = 2'h0;
    localparam logic [1:0] WIDTH_16 = 2'h1;
    localparam logic [1:0] WIDTH_32 = 2'h2;
    localparam logic [ADDR_W-1:0] ADDR_RST = 20'h00000;
    localparam logic [DATA_W-1:0] DATA_RST = 64'h0000000000000000;

    typedef enum logic [1:0]
    {
        OWN_IDLE = 2'b00,
        OWN_SDRAM = 2'b01,
        OWN_EXT = 2'b10
    } owner_t;

    typedef struct packed
    {
        logic req;
        logic [SD_ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
    } sdram_side_t;

    typedef struct packed
    {
        logic req;
        logic [1:0] width;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
    } ext_side_t;

    typedef struct packed
    {
        logic [ADDR_W-1:0] addr;
        logic [CFG_DATA_W-1:0] data;
    } boot_cfg_t;
endpackage

// *** hdl/ext_pin_interface.sv ***
// external address/data pin sharing between sdram and external bus controllers
// Function
// (R01) one 20-bit address and 64-bit data bus, one owner at a time
// (R02) address pins undriven during reset, driven only after release
// (R03) address pin levels captured as boot configuration during reset
// (R04) low sixteen data lines captured during reset; data stays input
// (R05) sdram cycles drive only address lines 19 to 5
// (R06) external bus address bit meaning follows channel data width
// (R07) bus_isolate_n high isolates slow devices, low attaches them
// (R08) configured pins take boot state in reset; bus_isolate_n held high
// (R09) bus_isolate_n low only around external bus cycles, else high
`timescale 1ns/1ps
module ext_pin_interface
    import ext_pin_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire sdram_side_t sdram_ctrl,
    input wire ext_side_t ext_bus_ctrl,
    output logic sdram_grant,
    output logic ext_grant,
    input wire logic [ADDR_W-1:0] addr_in,
    output logic [ADDR_W-1:0] addr_out,
    output logic [ADDR_W-1:0] addr_oe_n,
    input wire logic [DATA_W-1:0] data_in,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe_n,
    output logic [DATA_W-1:0] rdata,
    output logic bus_isolate_n,
    output boot_cfg_t boot_cfg
);
    owner_t owner;
    owner_t next_owner;
    logic [ADDR_W-1:0] next_addr_out;
    logic [ADDR_W-1:0] next_addr_oe_n;
    logic [DATA_W-1:0] next_data_out;
    logic next_data_oe_n;
    logic next_bus_isolate_n;
    boot_cfg_t next_boot_cfg;
    logic [DATA_W-1:0] next_rdata;
    logic [DATA_W-1:0] data_s1;
    logic [DATA_W-1:0] data_s2;
    logic [DATA_W-1:0] data_s3;
    logic [DATA_W-1:0] next_data_s1;
    logic [DATA_W-1:0] next_data_s2;
    logic [DATA_W-1:0] next_data_s3;
    logic [ADDR_W-1:0] addr_s1;
    logic [ADDR_W-1:0] addr_s2;
    logic [ADDR_W-1:0] addr_s3;
    logic [ADDR_W-1:0] next_addr_s1;
    logic [ADDR_W-1:0] next_addr_s2;
    logic [ADDR_W-1:0] next_addr_s3;
    logic addr_settled;
    logic cfg_data_settled;
    logic data_settled;

    // byte address to pin word for the given channel width
    function automatic logic [ADDR_W-1:0] ext_addr_map(input logic [1:0] w,
                                                      input logic [ADDR_W-1:0] a);
        case (w)
            WIDTH_8: ext_addr_map = a;
            WIDTH_16: ext_addr_map = {1'b0, a[ADDR_W-1:1]};
            WIDTH_32: ext_addr_map = {2'b00, a[ADDR_W-1:2]};
            default: ext_addr_map = a;
        endcase
    endfunction

    assign sdram_grant = (owner == OWN_SDRAM);
    assign ext_grant = (owner == OWN_EXT);

    // three-stage pin sampling
    always_comb
    begin
        next_addr_s1 = addr_in;
        next_addr_s2 = addr_s1;
        next_addr_s3 = addr_s2;
        next_data_s1 = data_in;
        next_data_s2 = data_s1;
        next_data_s3 = data_s2;
    end

    always_ff @(posedge clock)
    begin
        addr_s1 <= next_addr_s1;
        addr_s2 <= next_addr_s2;
        addr_s3 <= next_addr_s3;
        data_s1 <= next_data_s1;
        data_s2 <= next_data_s2;
        data_s3 <= next_data_s3;
    end

    // a pin change counts once the last two stages agree
    assign addr_settled = (addr_s2 == addr_s3);
    assign cfg_data_settled = (data_s2[CFG_DATA_W-1:0] == data_s3[CFG_DATA_W-1:0]);
    assign data_settled = (data_s2 == data_s3);

    // ownership: sdram first from idle, one idle cycle on every hand-over
    always_comb
    begin
        next_owner = OWN_IDLE;
        if (sys_rst)
        begin
            next_owner = OWN_IDLE;
        end
        else if (sdram_ctrl.req && owner != OWN_EXT)
        begin
            next_owner = OWN_SDRAM; // R01
        end
        else if (ext_bus_ctrl.req && owner != OWN_SDRAM)
        begin
            next_owner = OWN_EXT; // R01
        end
    end

    always_ff @(posedge clock)
    begin
        owner <= next_owner;
    end

    // address pins follow the owner being granted
    always_comb
    begin
        next_addr_out = addr_out;
        next_addr_oe_n = '0;
        case (next_owner)
            OWN_SDRAM:
            begin
                next_addr_out = {sdram_ctrl.addr, addr_out[SD_ADDR_LO-1:0]}; // R05
                next_addr_oe_n = {{SD_ADDR_W{1'b0}}, {SD_ADDR_LO{1'b1}}}; // R05
            end
            OWN_EXT:
            begin
                next_addr_out = ext_addr_map(ext_bus_ctrl.width, ext_bus_ctrl.addr); // R06
            end
            OWN_IDLE:
            begin
                next_addr_oe_n = '0;
            end
            default:
            begin
                next_addr_oe_n = '0;
            end
        endcase
        if (sys_rst)
        begin
            next_addr_out = ADDR_RST;
            next_addr_oe_n = '1; // R02
        end
    end

    always_ff @(posedge clock)
    begin
        addr_out <= next_addr_out;
        addr_oe_n <= next_addr_oe_n;
    end

    // data pins and the isolation buffer control
    always_comb
    begin
        next_data_out = data_out;
        next_data_oe_n = 1'b1;
        next_bus_isolate_n = 1'b1; // R09
        case (next_owner)
            OWN_SDRAM:
            begin
                next_data_out = sdram_ctrl.wdata;
                next_data_oe_n = ~sdram_ctrl.wr;
            end
            OWN_EXT:
            begin
                next_data_out = ext_bus_ctrl.wdata;
                next_data_oe_n = ~ext_bus_ctrl.wr;
                next_bus_isolate_n = 1'b0; // R07 R09
            end
            default:
            begin
                next_data_oe_n = 1'b1;
            end
        endcase
        if (sys_rst)
        begin
            next_data_out = DATA_RST;
            next_data_oe_n = 1'b1; // R04
            next_bus_isolate_n = 1'b1; // R08
        end
    end

    always_ff @(posedge clock)
    begin
        data_out <= next_data_out;
        data_oe_n <= next_data_oe_n;
        bus_isolate_n <= next_bus_isolate_n;
    end

    // boot straps taken while reset holds, kept after release
    always_comb
    begin
        next_boot_cfg = boot_cfg;
        if (sys_rst && addr_settled)
        begin
            next_boot_cfg.addr = addr_s3; // R03
        end
        if (sys_rst && cfg_data_settled)
        begin
            next_boot_cfg.data = data_s3[CFG_DATA_W-1:0]; // R04
        end
    end

    always_ff @(posedge clock)
    begin
        boot_cfg <= next_boot_cfg;
    end

    // read data taken while an owner leaves the data pins undriven
    always_comb
    begin
        next_rdata = rdata;
        if (sys_rst)
        begin
            next_rdata = DATA_RST;
        end
        else if (owner != OWN_IDLE && data_oe_n && data_settled)
        begin
            next_rdata = data_s3;
        end
    end

    always_ff @(posedge clock)
    begin
        rdata <= next_rdata;
    end
endmodule // ext_pin_interface

// *** tb/ext_pin_asserts.sv ***
// checker on the pin interface ports
`timescale 1ns/1ps
module ext_pin_asserts
    import ext_pin_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire sdram_side_t sdram_ctrl,
    input wire logic sdram_grant,
    input wire logic ext_grant,
    input wire logic [19:0] addr_oe_n,
    input wire logic data_oe_n,
    input wire logic bus_isolate_n
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    rst_a: assert property ($fell(sys_rst) |-> &addr_oe_n && bus_isolate_n)
        else $error("rst");
    own_a: assert property (!(sdram_grant && ext_grant)) else $error("own");
    rst_hold_a: assert property (disable iff (1'b0) sys_rst |=> &addr_oe_n && data_oe_n && bus_isolate_n)
        else $error("pins driven in reset");
    data_drive_a: assert property (!data_oe_n |-> sdram_grant || ext_grant)
        else $error("data driven without owner");
    take_a: assert property (sdram_ctrl.req && !sdram_grant && !ext_grant |=> sdram_grant)
        else $error("take");
    sd_a: assert property (sdram_grant |-> addr_oe_n == 20'h0001F) else $error("sd");
    ext_a: assert property (ext_grant |-> addr_oe_n == 20'h00000) else $error("ext");
    iso_a: assert property (bus_isolate_n != ext_grant) else $error("iso");
    gap_a: assert property ($rose(ext_grant) |-> !$past(sdram_grant)) else $error("gap");
    gap2_a: assert property ($rose(sdram_grant) |-> !$past(ext_grant)) else $error("gap");
endmodule // ext_pin_asserts

// *** tb/ext_pin_partner.sv ***
// far-side devices: boot straps, pull-ups, read data
`timescale 1ns/1ps
module ext_pin_partner
(
    input wire logic sys_rst,
    input wire logic bus_isolate_n,
    input wire logic [19:0] addr_out,
    input wire logic [19:0] addr_oe_n,
    input wire logic [63:0] data_out,
    input wire logic data_oe_n,
    output logic [19:0] addr_in,
    output logic [63:0] data_in
);
    localparam logic [35:0] CFG = 36'h5A3C1C3A5;
    localparam logic [63:0] RD = 64'h0123456789ABCDEF;
    assign addr_in = ~addr_oe_n & addr_out | addr_oe_n & (sys_rst ? CFG[35:16] : '1);
    assign data_in = !data_oe_n ? data_out : sys_rst ? {48'hFFFFFFFFFFFF, CFG[15:0]}
        : bus_isolate_n ? RD : ~RD ^ {44'h0, addr_out};
endmodule // ext_pin_partner

// *** tb/ext_pin_interface_tb_top.sv ***
// bench for the pin interface
`timescale 1ns/1ps
module ext_pin_interface_tb_top;
    import ext_pin_pkg::*;
    logic clock = 0, sys_rst = 1, sdram_grant, ext_grant, data_oe_n, bus_isolate_n;
    sdram_side_t sdram_ctrl = '0;
    ext_side_t ext_bus_ctrl = '0;
    logic [19:0] addr_in, addr_out, addr_oe_n;
    logic [63:0] data_in, data_out, rdata;
    boot_cfg_t boot_cfg;
    int errors = 0, n_checks = 0;
    ext_pin_interface dut
    (
        .clock(clock),
        .sys_rst(sys_rst),
        .sdram_ctrl(sdram_ctrl),
        .ext_bus_ctrl(ext_bus_ctrl),
        .sdram_grant(sdram_grant),
        .ext_grant(ext_grant),
        .addr_in(addr_in),
        .addr_out(addr_out),
        .addr_oe_n(addr_oe_n),
        .data_in(data_in),
        .data_out(data_out),
        .data_oe_n(data_oe_n),
        .rdata(rdata),
        .bus_isolate_n(bus_isolate_n),
        .boot_cfg(boot_cfg)
    );
    ext_pin_partner far
    (
        .sys_rst(sys_rst),
        .bus_isolate_n(bus_isolate_n),
        .addr_out(addr_out),
        .addr_oe_n(addr_oe_n),
        .data_out(data_out),
        .data_oe_n(data_oe_n),
        .addr_in(addr_in),
        .data_in(data_in)
    );
    task automatic chk(input logic [63:0] got, exp);
        n_checks++;
        if (got !== exp)
            $display("ERROR %0t got %h", $time, got);
        errors += (got !== exp);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic summarize;
        $display("errors %0d checks %0d", errors, n_checks);
        if (errors == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic boot_test;
        cyc(6);
        chk({addr_oe_n, data_oe_n, bus_isolate_n}, 22'h3FFFFF);
        sys_rst = 0;
        cyc(1);
        chk(boot_cfg, far.CFG);
    endtask
    task automatic share_test;
        sdram_ctrl = '{1'h1, 15'h6B2D, 64'h0, 1'h0};
        ext_bus_ctrl.req = 1;
        cyc(1);
        chk({sdram_grant, ext_grant, bus_isolate_n, addr_out[19:5]}, {3'h5, 15'h6B2D});
        cyc(4);
        chk(rdata, far.RD);
        sdram_ctrl.req = 0;
        cyc(2);
        chk({ext_grant, bus_isolate_n}, 2'h2);
        for (int w = 0; w < 3; w++)
        begin
            ext_bus_ctrl = '{1'h0, w[1:0], 20'hABCDE, ~far.RD, w[0]};
            cyc(2);
            ext_bus_ctrl.req = 1;
            cyc(1);
            chk({addr_out, data_oe_n, bus_isolate_n}, {20'hABCDE >> w, ~w[0], 1'h0});
            cyc(4);
            chk(w[0] ? data_out : rdata, w[0] ? ~far.RD : ~far.RD ^ (64'hABCDE >> w));
        end
    endtask
    task automatic reset_test;
        ext_bus_ctrl = '{1'h1, WIDTH_8, 20'h12345, 64'h0, 1'h1};
        cyc(1);
        chk({ext_grant, data_oe_n, addr_out}, {2'h2, 20'h12345});
        sys_rst = 1;
        cyc(1);
        chk({ext_grant, sdram_grant, addr_oe_n, data_oe_n, bus_isolate_n}, 24'h3FFFFF);
        cyc(5);
        sys_rst = 0;
        cyc(1);
        chk({boot_cfg, ext_grant, bus_isolate_n}, {far.CFG, 2'h2});
    endtask
    task automatic sdram_wr_test;
        ext_bus_ctrl.req = 0;
        sdram_ctrl = '{1'h1, 15'h1234, 64'hFEDCBA9876543210, 1'h1};
        cyc(1);
        chk({sdram_grant, ext_grant}, 2'h0);
        cyc(1);
        chk({sdram_grant, data_oe_n, bus_isolate_n, addr_out[19:5]}, {3'h5, 15'h1234});
        chk(addr_oe_n, 20'h0001F);
        chk(data_out, 64'hFEDCBA9876543210);
        sdram_ctrl.req = 0;
        cyc(2);
    endtask
    initial
        forever #10 clock = ~clock;
    initial
    begin
        boot_test;
        share_test;
        reset_test;
        sdram_wr_test;
        summarize;
    end
    initial
    begin
        repeat (1000) @(posedge clock);
        errors++;
        summarize;
    end
endmodule // ext_pin_interface_tb_top
bind ext_pin_interface ext_pin_asserts asrt
(
    .clock(clock),
    .sys_rst(sys_rst),
    .sdram_ctrl(sdram_ctrl),
    .sdram_grant(sdram_grant),
    .ext_grant(ext_grant),
    .addr_oe_n(addr_oe_n),
    .data_oe_n(data_oe_n),
    .bus_isolate_n(bus_isolate_n)
);
